// >>> inc/seq_pkg.sv
// package for the channel shutdown, retry and sync block
// assumes a 20 MHz reference clock and a shared time base on the share clock pin
package seq_pkg;
  localparam int NCH              = 2;       // output channels
  localparam int TW               = 16;      // width of programmed delays in ticks
  // channel_config bit positions
  localparam int CFG_NO_VOFF_BIT  = 0;       // retry ignores output voltage in the discharge variant
  localparam int CFG_SHARE_BIT    = 2;       // stop when share clock is lost
  // device_wide_config bit positions
  localparam int ALL_EXT_CLK_BIT  = 4;       // external clock is mandatory
  // pad_status bit positions
  localparam int PAD_SYNC_DRV_BIT = 10;      // sync driver is active
  // loop_compensation_setting fields
  localparam int COMP_RES_LSB     = 0;
  localparam int COMP_RES_MSB     = 4;
  localparam int COMP_GM_LSB      = 5;
  localparam int COMP_GM_MSB      = 7;
  // switcher_phase_config gain field
  localparam int GAIN_LSB         = 5;
  localparam int GAIN_MSB         = 6;
  localparam logic [7:0] COMP_RESET = 8'h00;
  // timing in its own units and in clock cycles
  localparam int CLK_PERIOD_NS    = 50;
  localparam int SYNC_PULSE_NS    = 500;
  localparam int SYNC_PULSE_CYC   = SYNC_PULSE_NS / CLK_PERIOD_NS;
  localparam int SYNC_GUARD_CYC   = 4;       // own edge echo through the synchroniser
  localparam int DISCH_HOLD_MS    = 90;      // least hold after discharge
  localparam int DISCH_HOLD_CYC   = (DISCH_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int SHARE_LOSS_US    = 20;      // share clock silent this long is lost
  localparam int SHARE_LOSS_CYC   = (SHARE_LOSS_US * 1000) / CLK_PERIOD_NS;

  // per-channel sequencing states
  typedef enum logic [3:0] {
    CH_OFF, CH_SOFTSTART, CH_RUN, CH_OFF_WAIT, CH_OFF_RAMP,
    CH_DISCHARGE, CH_HOLD, CH_RETRY, CH_LATCHED
  } ch_state_e;

  // per-channel configuration
  typedef struct packed {
    logic [TW-1:0] rise_time;                // soft-start length in ticks
    logic [TW-1:0] turn_off_wait;            // ticks before the ramp down
    logic [TW-1:0] turn_off_ramp_time;       // ramp down length in ticks
    logic [TW-1:0] retry_wait;               // least inactive time in ticks
    logic [TW-1:0] max_discharge_time_limit; // warning limit in ticks
    logic [7:0]    channel_config;
    logic          ccm_run;                  // conduction_mode_select: 1 forced continuous
    logic          latch_off;                // 1 latch off on fault, 0 retry
    logic          external_fault_action;    // 1 inhibit on external fault pin
  } ch_cfg_s;

  // per-channel status towards the power stage
  typedef struct packed {
    logic stage_en;                          // power stage may switch
    logic ccm;                               // 1 continuous, 0 discontinuous
    logic sink;                              // actively sink load current
    logic soft_start;
    logic running;
    logic retry_pend;
    logic latched;
  } ch_out_s;

  // frequency and phase configuration
  typedef struct packed {
    logic [15:0] period;                     // switching period in clock cycles
    logic [7:0]  phase_ch1;                  // sync fall to top switch, cycles
    logic [7:0]  phase_ch0;
    logic [7:0]  switcher_phase_config;
  } sw_cfg_s;
endpackage

// >>> logic/sync_master.sv
// sync line driver, master election and phase reference
// assumes an open-drain sync line with a pull-up; SYNC_I is asynchronous
`timescale 1ns/1ps
module sync_master (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        master_en,   // configured as clock master
  input  wire logic        ext_req,     // external clock is mandatory
  input  wire logic [15:0] period,      // switching period in cycles
  input  wire logic        sync_i,      // line level
  output logic             sync_o,      // drive level, always low
  output logic             sync_oe_n,   // low while pulling the line
  output logic             drv_active,  // driver is elected
  output logic             ref_pulse,   // phase reference event
  output logic             pll_fault    // no clock while one is required
);
  logic [1:0]  sy_r;                    // synchroniser pair
  logic        ln_r,      ln_nxt;       // delayed line sample
  logic [15:0] per_r,     per_nxt;      // internal oscillator
  logic [7:0]  pc_r,      pc_nxt;       // own pulse and echo window
  logic [16:0] ext_r,     ext_nxt;      // cycles since external edge
  logic        yield_r,   yield_nxt;    // lost the election
  logic        oe_n_nxt,  ref_nxt, act_nxt, pf_nxt;
  logic        fall, ext_fall, ext_ok, wrap;

  // line passes two flip-flops before use
  always_ff @(posedge clk) begin
    if (srst) begin
      sy_r <= 2'h3;
    end else begin
      sy_r <= {sy_r[0], sync_i};
    end
  end

  // next state of oscillator, election and reference
  always_comb begin
    ln_nxt    = sy_r[1];
    fall      = ln_r & ~sy_r[1];
    ext_fall  = fall & (pc_r == 8'h00);                   // not our own echo
    ext_ok    = ext_r < {period, 1'b0};
    wrap      = per_r >= period - 16'h0001;
    per_nxt   = (wrap | ext_fall) ? 16'h0000 : per_r + 16'h0001;
    yield_nxt = master_en & (yield_r | ext_fall);         // (R17) (R18)
    act_nxt   = master_en & ~yield_nxt;
    pc_nxt    = pc_r;
    if (wrap && act_nxt) begin
      pc_nxt = 8'(seq_pkg::SYNC_PULSE_CYC + seq_pkg::SYNC_GUARD_CYC);
    end else if (pc_r != 8'h00) begin
      pc_nxt = pc_r - 8'h01;
    end
    // pull low for the pulse width only (R16)
    oe_n_nxt  = ~(act_nxt && pc_nxt > 8'(seq_pkg::SYNC_GUARD_CYC));
    ext_nxt   = ext_fall ? 17'h00000 : (ext_ok ? ext_r + 17'h00001 : ext_r);
    // line fall is the reference; internal wrap when no clock arrives and ext_req is clear (R18) (R20)
    ref_nxt   = (ext_ok | act_nxt) ? fall : (wrap & ~ext_req);
    pf_nxt    = ext_req & ~ext_ok;
  end

  // registers of the sync logic
  always_ff @(posedge clk) begin
    if (srst) begin
      ln_r       <= 1'b1;
      per_r      <= 16'h0000;
      pc_r       <= 8'h00;
      ext_r      <= 17'h1ffff;
      yield_r    <= 1'b0;
      sync_o     <= 1'b0;
      sync_oe_n  <= 1'b1;
      drv_active <= 1'b0;
      ref_pulse  <= 1'b0;
      pll_fault  <= 1'b0;
    end else begin
      ln_r       <= ln_nxt;
      per_r      <= per_nxt;
      pc_r       <= pc_nxt;
      ext_r      <= ext_nxt;
      yield_r    <= yield_nxt;
      sync_o     <= 1'b0;
      sync_oe_n  <= oe_n_nxt;
      drv_active <= act_nxt;
      ref_pulse  <= ref_nxt;
      pll_fault  <= pf_nxt;
    end
  end
endmodule // sync_master

// >>> logic/channel_shutdown_retry_sync.sv
// channel shutdown, fault retry and sync handling for a dual-output controller
// assumes channel and device-wide configuration is held by the command interface outside this block
// and that sense comparators and converter flags arrive on REF_CLK
//
// Overview of operation
// (R1) three shutdown modes: ramp, passive, immediate; run-off here only ramps, or discharges in the variant build
// (R2) continuous: wait, then ramp down sinking current
// (R3) discontinuous shutdown never sinks load current
// (R4) fault, share loss, low input, inhibit disable stage
// (R5) shutdown from soft-start or regulation, any cause
// (R6) discharge variant: switch until low, hold 90ms
// (R7) retry: fault holds channel off for delay
// (R8) base: delay also waits output below 12.5%
// (R9) variant bit0 clear: wait threshold, warn if slow
// (R10) variant bit0 set: delay only, no warning
// (R11) shared fault pin: faulted output sets decay
// (R12) latch-off stays off until user toggles
// (R13) start discontinuous, run in programmed mode
// (R14) input overvoltage turns off that channel
// (R15) compensation: resistor bits 4:0, gm 7:5
// (R16) master pulses sync low for 500ns
// (R17) only one elected master drives sync
// (R18) accept external sync, fall back unless required
// (R19) sync driver state on pad status bit 10
// (R20) phase measured from sync falling edge
// (R21) frequency and phase writes only when off
// (R22) input current gain from bits 6:5
// (R23) retry timer starts inactive, counts shared ticks
`timescale 1ns/1ps
module channel_shutdown_retry_sync #(
  parameter bit          DISCHARGE_VARIANT = 1'b0,                 // discharge shutdown build
  parameter int unsigned DISCH_HOLD_CYC    = seq_pkg::DISCH_HOLD_CYC,
  parameter int unsigned SHARE_LOSS_CYC    = seq_pkg::SHARE_LOSS_CYC
) (
  input  wire logic                                   REF_CLK,
  input  wire logic                                   SRST,
  input  wire logic [seq_pkg::NCH-1:0]                RUN_PIN,      // run pins, async
  input  wire logic [seq_pkg::NCH-1:0]                FAULT_N_I,    // fault pins, async
  input  wire logic                                   SHARE_CLK_I,  // shared time base
  input  wire logic                                   SYNC_I,       // sync line level
  input  wire logic [seq_pkg::NCH-1:0]                OP_ON,        // operation on command
  input  wire logic [seq_pkg::NCH-1:0]                FAULT_DET,    // detected channel fault
  input  wire logic [seq_pkg::NCH-1:0]                VIN_OV,       // input overvoltage
  input  wire logic                                   VIN_BELOW_OFF,
  input  wire logic [seq_pkg::NCH-1:0]                VOUT_BELOW_8TH,
  input  wire logic [seq_pkg::NCH-1:0]                VOUT_BELOW_DONE,
  input  wire seq_pkg::ch_cfg_s [seq_pkg::NCH-1:0]    CH_CFG,
  input  wire logic [7:0]                             DEVICE_WIDE_CONFIG,
  input  wire logic                                   SYNC_MASTER_EN,
  input  wire logic [seq_pkg::NCH-1:0]                WARN_CLR,     // clear slow warning
  input  wire logic                                   COMP_WR,
  input  wire logic [7:0]                             COMP_WDATA,
  input  wire logic                                   SWCFG_WR,
  input  wire seq_pkg::sw_cfg_s                       SWCFG_WDATA,
  output seq_pkg::ch_out_s [seq_pkg::NCH-1:0]         CH_STAT,
  output logic [seq_pkg::NCH-1:0]                     SLOW_DISCHARGE_WARNING,
  output logic [seq_pkg::NCH-1:0]                     TOP_ON,       // top switch turn-on
  output logic [7:0]                                  LOOP_COMPENSATION_SETTING,
  output logic [4:0]                                  COMP_RES,
  output logic [2:0]                                  COMP_GM,
  output logic [1:0]                                  IIN_GAIN,
  output seq_pkg::sw_cfg_s                            SWCFG_RDATA,
  output logic [15:0]                                 PAD_STATUS,
  output logic                                        PLL_FAULT,
  output logic                                        SYNC_O,
  output logic                                        SYNC_OE_N
);
  logic [seq_pkg::NCH-1:0] run_m_r, run_s_r;     // run synchroniser
  logic [seq_pkg::NCH-1:0] flt_m_r, flt_s_r;     // fault pin synchroniser
  logic [1:0]              sh_r;                 // share clock synchroniser
  logic                    sh_d_r, sh_d_nxt;     // previous share sample
  logic                    tick;                 // shared time base edge
  logic [31:0]             sloss_r, sloss_nxt;   // cycles since last tick
  logic                    share_lost;
  logic [7:0]              comp_r, comp_nxt;     // loop_compensation_setting
  seq_pkg::sw_cfg_s        sw_r, sw_nxt;         // frequency and phase config
  logic [seq_pkg::NCH-1:0] stage_v;              // per-channel stage enables
  logic                    all_off;
  logic [15:0]             pad_nxt;
  logic                    drv_active, ref_pulse, pll_fault;

  // pins pass two flip-flops before any logic reads them
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      run_m_r <= '0;
      run_s_r <= '0;
      flt_m_r <= '1;
      flt_s_r <= '1;
      sh_r    <= 2'h0;
    end else begin
      run_m_r <= RUN_PIN;
      run_s_r <= run_m_r;
      flt_m_r <= FAULT_N_I;
      flt_s_r <= flt_m_r;
      sh_r    <= {sh_r[0], SHARE_CLK_I};
    end
  end

  // shared time base: rising edges are ticks, silence means lost
  always_comb begin
    sh_d_nxt   = sh_r[1];
    tick       = sh_r[1] & ~sh_d_r;
    share_lost = sloss_r >= 32'(SHARE_LOSS_CYC);
    sloss_nxt  = tick ? 32'h0 : (share_lost ? sloss_r : sloss_r + 32'h1);
  end

  // time base registers
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sh_d_r  <= 1'b0;
      sloss_r <= 32'(SHARE_LOSS_CYC);
    end else begin
      sh_d_r  <= sh_d_nxt;
      sloss_r <= sloss_nxt;
    end
  end

  // configuration registers
  always_comb begin
    all_off = ~|stage_v;
    comp_nxt = COMP_WR ? COMP_WDATA : comp_r;
    // writes while a channel is on are dropped (R21)
    sw_nxt = (SWCFG_WR && all_off) ? SWCFG_WDATA : sw_r;
    pad_nxt = 16'h0000;
    pad_nxt[seq_pkg::PAD_SYNC_DRV_BIT] = drv_active;   // (R19)
  end

  // configuration and pad status registers
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      comp_r     <= seq_pkg::COMP_RESET;
      sw_r       <= '0;
      PAD_STATUS <= 16'h0000;
      PLL_FAULT  <= 1'b0;
    end else begin
      comp_r     <= comp_nxt;
      sw_r       <= sw_nxt;
      PAD_STATUS <= pad_nxt;
      PLL_FAULT  <= pll_fault;
    end
  end

  // outputs taken straight from the configuration flip-flops
  assign LOOP_COMPENSATION_SETTING = comp_r;
  assign COMP_RES    = comp_r[seq_pkg::COMP_RES_MSB:seq_pkg::COMP_RES_LSB];   // (R15)
  assign COMP_GM     = comp_r[seq_pkg::COMP_GM_MSB:seq_pkg::COMP_GM_LSB];     // (R15)
  assign IIN_GAIN    = sw_r.switcher_phase_config[seq_pkg::GAIN_MSB:seq_pkg::GAIN_LSB]; // (R22)
  assign SWCFG_RDATA = sw_r;

  // sync line driver and election
  sync_master u_sync (
    .clk        (REF_CLK),
    .srst       (SRST),
    .master_en  (SYNC_MASTER_EN),
    .ext_req    (DEVICE_WIDE_CONFIG[seq_pkg::ALL_EXT_CLK_BIT]),
    .period     (sw_r.period),
    .sync_i     (SYNC_I),
    .sync_o     (SYNC_O),
    .sync_oe_n  (SYNC_OE_N),
    .drv_active (drv_active),
    .ref_pulse  (ref_pulse),
    .pll_fault  (pll_fault)
  );

  // one sequencer per channel
  for (genvar c = 0; c < seq_pkg::NCH; c++) begin : g_ch
    seq_pkg::ch_state_e st_r, st_nxt;             // sequencing state
    logic [31:0]        tmr_r, tmr_nxt;           // ticks or cycles in state
    logic [31:0]        wcnt_r, wcnt_nxt;         // ticks of slow discharge
    logic               exto_r, exto_nxt;         // shut by a cause other than its own fault
    logic               warn_r, warn_nxt;         // slow discharge warning
    logic [7:0]         ph_r, ph_nxt;             // phase countdown
    logic               pha_r, pha_nxt;           // phase countdown active
    logic               top_r, top_nxt;
    seq_pkg::ch_out_s   out_r, out_nxt;
    logic               own, kill, on_req, decay_ok, ext_flt, nov;
    logic [7:0]         phase;

    // shutdown causes and on request
    always_comb begin
      nov     = CH_CFG[c].channel_config[seq_pkg::CFG_NO_VOFF_BIT];
      ext_flt = ~flt_s_r[c] & CH_CFG[c].external_fault_action;
      own     = FAULT_DET[c] | VIN_OV[c];                         // (R14)
      kill    = own | ext_flt | VIN_BELOW_OFF                     // (R4)
              | (CH_CFG[c].channel_config[seq_pkg::CFG_SHARE_BIT] & share_lost);
      on_req  = run_s_r[c] & OP_ON[c];
      if (!DISCHARGE_VARIANT) begin
        decay_ok = VOUT_BELOW_8TH[c];                             // (R8)
      end else begin
        decay_ok = nov | VOUT_BELOW_DONE[c];                      // (R9) (R10)
      end
    end

    // next state of the channel sequencer
    always_comb begin
      st_nxt   = st_r;
      tmr_nxt  = tick ? tmr_r + 32'h1 : tmr_r;
      wcnt_nxt = wcnt_r;
      exto_nxt = exto_r;
      warn_nxt = warn_r & ~WARN_CLR[c];
      case (st_r)
        seq_pkg::CH_OFF: begin
          tmr_nxt = 32'h0;
          if (on_req && !kill) begin
            st_nxt = seq_pkg::CH_SOFTSTART;
          end
        end
        seq_pkg::CH_SOFTSTART, seq_pkg::CH_RUN: begin               // (R5)
          if (kill) begin
            st_nxt   = CH_CFG[c].latch_off ? seq_pkg::CH_LATCHED : seq_pkg::CH_RETRY; // (R7) (R12)
            tmr_nxt  = 32'h0;                                     // (R23)
            wcnt_nxt = 32'h0;
            exto_nxt = ~own;
          end else if (!on_req) begin
            st_nxt  = DISCHARGE_VARIANT ? seq_pkg::CH_DISCHARGE : seq_pkg::CH_OFF_WAIT; // (R1)
            tmr_nxt = 32'h0;
          end else if (st_r == seq_pkg::CH_SOFTSTART &&
                       tmr_r >= {16'h0, CH_CFG[c].rise_time}) begin
            st_nxt = seq_pkg::CH_RUN;
          end
        end
        seq_pkg::CH_OFF_WAIT: begin
          if (kill) begin
            st_nxt = seq_pkg::CH_OFF;                             // (R4)
          end else if (tmr_r >= {16'h0, CH_CFG[c].turn_off_wait}) begin
            st_nxt  = seq_pkg::CH_OFF_RAMP;                       // (R2)
            tmr_nxt = 32'h0;
          end
        end
        seq_pkg::CH_OFF_RAMP: begin
          if (kill || tmr_r >= {16'h0, CH_CFG[c].turn_off_ramp_time}) begin
            st_nxt = seq_pkg::CH_OFF;                             // (R2)
          end
        end
        seq_pkg::CH_DISCHARGE: begin
          if (kill) begin
            st_nxt = seq_pkg::CH_OFF;
          end else if (VOUT_BELOW_DONE[c]) begin
            st_nxt  = seq_pkg::CH_HOLD;                           // (R6)
            tmr_nxt = 32'h0;
          end
        end
        seq_pkg::CH_HOLD: begin
          tmr_nxt = tmr_r + 32'h1;                                // counts clock cycles
          if (kill || tmr_r >= 32'(DISCH_HOLD_CYC) - 32'h1) begin
            st_nxt = seq_pkg::CH_OFF;                             // (R6)
          end
        end
        seq_pkg::CH_RETRY: begin
          // slow discharge is timed from the fault-off moment
          if (DISCHARGE_VARIANT && !nov && !VOUT_BELOW_DONE[c] && tick) begin
            wcnt_nxt = wcnt_r + 32'h1;
          end
          if (DISCHARGE_VARIANT && !nov &&
              wcnt_r > {16'h0, CH_CFG[c].max_discharge_time_limit}) begin
            warn_nxt = 1'b1;                                      // (R9)
          end
          if (!on_req) begin
            st_nxt = seq_pkg::CH_OFF;
          end else if (tmr_r >= {16'h0, CH_CFG[c].retry_wait} && decay_ok &&
                       !(exto_r && !flt_s_r[c])) begin            // (R7) (R11)
            st_nxt = seq_pkg::CH_OFF;
          end
        end
        seq_pkg::CH_LATCHED: begin
          if (!on_req) begin
            st_nxt = seq_pkg::CH_OFF;                             // (R12)
          end
        end
        default: begin
          st_nxt = seq_pkg::CH_OFF;
        end
      endcase
      // status follows the next state so outputs move with it
      out_nxt            = '0;
      out_nxt.soft_start = st_nxt == seq_pkg::CH_SOFTSTART;
      out_nxt.running    = st_nxt == seq_pkg::CH_RUN;
      out_nxt.retry_pend = st_nxt == seq_pkg::CH_RETRY;
      out_nxt.latched    = st_nxt == seq_pkg::CH_LATCHED;
      out_nxt.stage_en   = st_nxt inside {seq_pkg::CH_SOFTSTART, seq_pkg::CH_RUN,
                           seq_pkg::CH_OFF_WAIT, seq_pkg::CH_OFF_RAMP,
                           seq_pkg::CH_DISCHARGE, seq_pkg::CH_HOLD};
      // discontinuous at start, programmed mode in run and ramp, continuous in discharge and hold (R13)
      out_nxt.ccm        = (st_nxt inside {seq_pkg::CH_RUN, seq_pkg::CH_OFF_WAIT,
                           seq_pkg::CH_OFF_RAMP} && CH_CFG[c].ccm_run)
                         || st_nxt inside {seq_pkg::CH_DISCHARGE, seq_pkg::CH_HOLD};
      // only continuous conduction sinks current (R2) (R3)
      out_nxt.sink       = out_nxt.ccm && st_nxt inside {seq_pkg::CH_OFF_RAMP,
                           seq_pkg::CH_DISCHARGE, seq_pkg::CH_HOLD};
    end

    // top switch turn-on delayed from the sync reference
    always_comb begin
      phase   = (c == 0) ? sw_r.phase_ch0 : sw_r.phase_ch1;
      ph_nxt  = ph_r;
      pha_nxt = pha_r;
      top_nxt = 1'b0;
      if (ref_pulse) begin
        ph_nxt  = phase;                                          // (R20)
        pha_nxt = 1'b1;
      end else if (pha_r && ph_r == 8'h00) begin
        pha_nxt = 1'b0;
        top_nxt = out_r.stage_en;
      end else if (pha_r) begin
        ph_nxt = ph_r - 8'h01;
      end
    end

    // channel registers
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        st_r   <= seq_pkg::CH_OFF;
        tmr_r  <= 32'h0;
        wcnt_r <= 32'h0;
        exto_r <= 1'b0;
        warn_r <= 1'b0;
        out_r  <= '0;
        ph_r   <= 8'h00;
        pha_r  <= 1'b0;
        top_r  <= 1'b0;
      end else begin
        st_r   <= st_nxt;
        tmr_r  <= tmr_nxt;
        wcnt_r <= wcnt_nxt;
        exto_r <= exto_nxt;
        warn_r <= warn_nxt;
        out_r  <= out_nxt;
        ph_r   <= ph_nxt;
        pha_r  <= pha_nxt;
        top_r  <= top_nxt;
      end
    end

    assign stage_v[c]                = out_r.stage_en;
    assign CH_STAT[c]                = out_r;
    assign SLOW_DISCHARGE_WARNING[c] = warn_r;
    assign TOP_ON[c]                 = top_r;
  end
endmodule // channel_shutdown_retry_sync

// >>> sim/peer_node.sv
// peer controller on the shared time base and sync line
// assumes the bench wires sync_pull into the pulled-up sync line
`timescale 1ns/1ps
module peer_node (
  input  wire logic clk,
  input  wire logic ext_en,     // peer acts as the elected clock master
  output logic      share_clk,  // free running shared time base
  output logic      sync_pull   // high while the peer pulls sync low
);
  int n = 0;                    // peer period counter, 130 cycles
  initial begin
    share_clk = 1'b0;
    sync_pull = 1'b0;
  end
  // time base ticks about every 8 cycles; sync pulse is 10 cycles long
  always @(posedge clk) begin
    n <= (n == 129) ? 0 : n + 1;
    if (n % 4 == 0) share_clk <= ~share_clk;
    sync_pull <= ext_en && (n < 10);
  end
endmodule // peer_node

// >>> sim/channel_shutdown_retry_sync_assertions.sv
// timing checks on the top module outputs
// assumes it is bound onto channel_shutdown_retry_sync
`timescale 1ns/1ps
module csrs_chk (
  input wire logic                             REF_CLK,
  input wire logic                             SRST,
  input wire logic                             COMP_WR,
  input wire logic [7:0]                       COMP_WDATA,
  input wire logic                             SWCFG_WR,
  input wire logic [seq_pkg::NCH-1:0]          FAULT_DET,
  input wire seq_pkg::ch_out_s [seq_pkg::NCH-1:0] CH_STAT,
  input wire logic [7:0]                       LOOP_COMPENSATION_SETTING,
  input wire logic [4:0]                       COMP_RES,
  input wire logic [2:0]                       COMP_GM,
  input wire logic [1:0]                       IIN_GAIN,
  input wire seq_pkg::sw_cfg_s                 SWCFG_RDATA,
  input wire logic [15:0]                      PAD_STATUS,
  input wire logic                             SYNC_O,
  input wire logic                             SYNC_OE_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  sequence s_pull; !SYNC_OE_N [*8] ##1 !SYNC_OE_N [*2]; endsequence
  chk_sync_width: assert property ($fell(SYNC_OE_N) |-> s_pull ##1 SYNC_OE_N)
    else $error("sync pulse width wrong");
  chk_pad_drive: assert property (!SYNC_OE_N |-> PAD_STATUS[10] && !SYNC_O)
    else $error("driver status not shown");
  chk_comp_write: assert property (COMP_WR |=> LOOP_COMPENSATION_SETTING == $past(COMP_WDATA))
    else $error("compensation write lost");
  chk_comp_fields: assert property (COMP_RES == LOOP_COMPENSATION_SETTING[4:0]
    && COMP_GM == LOOP_COMPENSATION_SETTING[7:5]) else $error("compensation field");
  chk_gain_field: assert property (IIN_GAIN == SWCFG_RDATA.switcher_phase_config[6:5])
    else $error("gain field wrong");
  chk_cfg_refused: assert property (SWCFG_WR
    && (CH_STAT[0].stage_en || CH_STAT[1].stage_en)
    |=> $stable(SWCFG_RDATA)) else $error("config taken while on");
  chk_fault_kill: assert property (FAULT_DET[0] |-> ##[1:2] !CH_STAT[0].stage_en)
    else $error("stage not disabled");
  chk_start_dcm: assert property (CH_STAT[0].soft_start |-> !CH_STAT[0].ccm)
    else $error("soft start not discontinuous");
  chk_dcm_nosink: assert property (!CH_STAT[0].ccm |-> !CH_STAT[0].sink)
    else $error("sink in discontinuous");
endmodule // csrs_chk
bind channel_shutdown_retry_sync csrs_chk u_chk (.REF_CLK, .SRST, .COMP_WR, .COMP_WDATA,
  .SWCFG_WR, .FAULT_DET, .CH_STAT, .LOOP_COMPENSATION_SETTING, .COMP_RES, .COMP_GM,
  .IIN_GAIN, .SWCFG_RDATA, .PAD_STATUS, .SYNC_O, .SYNC_OE_N);

// >>> sim/channel_shutdown_retry_sync_test.sv
// directed bench for shutdown, retry, register and sync behaviour
// assumes peer_node and the bound checker; time base ticks about every 8 cycles
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module channel_shutdown_retry_sync_test;
  logic REF_CLK = 0, SRST = 1, COMP_WR = 0, SWCFG_WR = 0, VIN_BELOW_OFF = 0;
  logic SYNC_MASTER_EN = 0, ext_en = 0, SHARE_CLK_I, sync_pull, PLL_FAULT, SYNC_O, SYNC_OE_N;
  logic [1:0] RUN_PIN = 0, FAULT_N_I = 3, OP_ON = 0, FAULT_DET = 0, VIN_OV = 0, WARN_CLR = 0;
  logic [1:0] VOUT_BELOW_8TH = 0, VOUT_BELOW_DONE = 0, SLOW_DISCHARGE_WARNING, TOP_ON, IIN_GAIN;
  logic [7:0] COMP_WDATA = 0, DEVICE_WIDE_CONFIG = 0, LOOP_COMPENSATION_SETTING;
  logic [4:0] COMP_RES;
  logic [2:0] COMP_GM;
  logic [15:0] PAD_STATUS;
  seq_pkg::sw_cfg_s SWCFG_WDATA = '0, SWCFG_RDATA;
  seq_pkg::ch_cfg_s [1:0] CH_CFG;
  seq_pkg::ch_out_s [1:0] CH_STAT;
  int fail_count = 0, n_checks = 0, k;
  wire SYNC_I = SYNC_OE_N & !sync_pull;  // pulled-up open-drain line
  channel_shutdown_retry_sync #(.DISCH_HOLD_CYC(50), .SHARE_LOSS_CYC(40)) u_dut (.*);
  peer_node u_peer (.clk(REF_CLK), .ext_en(ext_en), .share_clk(SHARE_CLK_I), .sync_pull);
  initial forever #25 REF_CLK = ~REF_CLK;
  task step; @(posedge REF_CLK); #1; endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_comp;
    COMP_WDATA = 8'h6b; COMP_WR = 1; step; COMP_WR = 0; step;
    `CHK(COMP_RES, 5'h0b)
    `CHK(COMP_GM, 3'h3)
    $display("t_comp done");
  endtask
  task t_swcfg(input logic [7:0] v, input logic [1:0] e);
    SWCFG_WDATA = '{16'd100, 8'd5, 8'd9, v}; SWCFG_WR = 1; step; SWCFG_WR = 0; step;
    `CHK(IIN_GAIN, e)
    $display("t_swcfg done");
  endtask
  task t_sync;
    SYNC_MASTER_EN = 1;
    for (k = 0; k < 300 && SYNC_OE_N; k++) step;
    `CHK(PAD_STATUS[10], 1'b1)
    for (k = 0; k < 50 && !SYNC_OE_N; k++) step;
    `CHK(k, 10)
    ext_en = 1; repeat (400) step;
    `CHK(SYNC_OE_N, 1'b1)
    `CHK(PAD_STATUS[10], 1'b0)
    $display("t_sync done");
  endtask
  task t_start;
    RUN_PIN[0] = 1; OP_ON[0] = 1;
    for (k = 0; k < 20 && !CH_STAT[0].stage_en; k++) step;
    `CHK(CH_STAT[0].soft_start, 1'b1)
    `CHK(CH_STAT[0].ccm, 1'b0)
    for (k = 0; k < 300 && !CH_STAT[0].running; k++) step;
    `CHK(CH_STAT[0].ccm, 1'b1)
    $display("t_start done");
  endtask
  task t_fault;
    FAULT_DET[0] = 1; step; FAULT_DET[0] = 0; step;
    `CHK(CH_STAT[0].stage_en, 1'b0)
    `CHK(CH_STAT[0].retry_pend, 1'b1)
    VOUT_BELOW_8TH = 2'b11;
    for (k = 0; k < 500 && CH_STAT[0].retry_pend; k++) step;
    `CHK(k >= 16 && k < 500, 1'b1)
    for (k = 0; k < 20 && !CH_STAT[0].soft_start; k++) step;
    `CHK(CH_STAT[0].soft_start, 1'b1)
    VIN_BELOW_OFF = 1; step; step; VIN_BELOW_OFF = 0; VOUT_BELOW_8TH = 0;
    `CHK(CH_STAT[0].stage_en, 1'b0)
    repeat (60) step;
    `CHK(CH_STAT[0].retry_pend, 1'b1)
    VOUT_BELOW_8TH = 2'b11;
    for (k = 0; k < 900 && !CH_STAT[0].running; k++) step;
    `CHK(CH_STAT[0].running, 1'b1)
    $display("t_fault done");
  endtask
  task t_off;
    OP_ON[0] = 0;
    for (k = 0; k < 300 && !CH_STAT[0].sink; k++) step;
    `CHK(CH_STAT[0].sink, 1'b1)
    for (k = 0; k < 300 && CH_STAT[0].stage_en; k++) step;
    `CHK(CH_STAT[0].stage_en, 1'b0)
    $display("t_off done");
  endtask
  initial begin
    CH_CFG[0] = '{16'd3, 16'd2, 16'd3, 16'd4, 16'd20, 8'h00, 1'b1, 1'b0, 1'b0};
    CH_CFG[1] = CH_CFG[0];
    repeat (16) @(posedge REF_CLK);
    #1 SRST = 0; step;
    t_comp; t_swcfg(8'h40, 2'h2); t_sync; t_start;
    t_swcfg(8'h20, 2'h2); t_fault; t_off;
    close_out;
  end
  // watchdog for a hung wait
  initial begin #1500000; fail_count++; close_out; end
endmodule // channel_shutdown_retry_sync_test
